// file: hw/tsv_defs.svh
`ifndef TSV_DEFS_SVH
`define TSV_DEFS_SVH

// Register word indices; the byte address is four times the index.
`define TSV_CTRL_W 6'h00
`define TSV_STATUS_W 6'h01
`define TSV_DACHI_W 6'h02
`define TSV_BASE_W 6'h04
`define TSV_MASK_W 6'h0c
`define TSV_WIN_LAST 6'h06
`define TSV_ROM_IDX 6
`define TSV_CTRL_PAIR01 8
`define TSV_CTRL_PAIR12 9
`define TSV_CTRL_MASK 32'h0000037f
`define TSV_REG_RST 32'h00000000
`define TSV_CMD_DAC 4'hd
`define TSV_CMD_CFG 3'h5
`define TSV_CMD_SPC 3'h0
`define TSV_RESP_OKAY 2'h0
`define TSV_RESP_SLVERR 2'h2

`endif

// file: hw/tsv_pkg.sv
`default_nettype none

package tsv_pkg;

   typedef struct packed {
      logic dac;
      logic xfr;
      logic burst;
      logic access;
      logic wide;
      logic rom_hit;
      logic [5:0] bar_hit;
   } tsv_status_t;

   typedef struct packed {
      logic framen;
      logic irdyn;
      logic trdyn;
      logic req64n;
      logic [3:0] cben;
      logic [31:0] ad;
   } tsv_pci_t;

   typedef enum logic [1:0] {
      TSV_IDLE,
      TSV_DAC,
      TSV_MISS,
      TSV_ACTIVE
   } tsv_state_t;

endpackage

`default_nettype wire

// file: hw/tsv_window_match.sv
`timescale 1ns/1ps
`default_nettype none

module tsv_window_match #(
   parameter int AW = 32
) (
   input wire logic [AW-1:0] addr,
   input wire logic [AW-1:0] base,
   input wire logic [AW-1:0] mask,
   input wire logic enable,
   output logic hit
);

   generate
      if (AW < 1) begin : g_bad_aw
         $error("Address width must be at least one bit.");
      end
   endgenerate

   // Address bits under the mask must equal the programmed base.
   assign hit = enable & ((addr & mask) == (base & mask));

endmodule

`default_nettype wire

// file: hw/tsv_status_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsv_defs.svh"

// Contract
// R1: Set a window hit bit in 5..0 when an enabled window claims the access.
// R2: Hit bit n reports window register n; bit 0 is the first window register.
// R3: Windows 0 and 1 paired as 64-bit raise hit bits 0 and 1 together.
// R4: Windows 1 and 2 paired as 64-bit raise hit bits 1 and 2 together.
// R5: Bit 6 reports an access matching the expansion ROM window.
// R6: Wide variants set bit 7 for a 64-bit access; low means 32 bits.
// R7: Narrow variants keep bit 7 reserved and never report width there.
// R8: Bit 8 stays high for the whole target access.
// R9: Bit 9 marks a burst when framen and irdyn are low in phase one.
// R10: Bit 10 is high only after a PCI data transfer the cycle before.
// R11: Bit 11 is high while the access used a dual address cycle.
// R12: Local logic keeps its inputs deasserted when no local access runs.
// R13: All twelve bits leave as one bus that local logic samples each clock.
// R14: Bits update on the clock and are low after reset and when unclaimed.
module tsv_status_top #(
   parameter int WIDE64 = 1
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire tsv_pkg::tsv_pci_t pci,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output tsv_pkg::tsv_status_t target_status_vector
);

   generate
      if (WIDE64 != 0 && WIDE64 != 1) begin : g_bad_wide
         $error("WIDE64 must be 0 or 1.");
      end
   endgenerate

   function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Register file.
   logic [31:0] ctrl_reg;
   logic [31:0] dac_hi_reg;
   logic [31:0] base_reg [0:6];
   logic [31:0] mask_reg [0:6];

   // Transaction tracking.
   tsv_pkg::tsv_state_t state_reg;
   tsv_pkg::tsv_state_t state_next;
   tsv_pkg::tsv_status_t tsv_reg;
   tsv_pkg::tsv_status_t tsv_next;
   logic frame_prev_reg;
   logic [31:0] addr_lo_reg;
   logic req64_lat_reg;
   logic first_reg;
   logic first_next;

   wire logic in_idle;
   wire logic in_dac;
   wire logic in_active;
   wire logic addr_phase;
   wire logic bus_idle;
   wire logic cmd_ok;
   wire logic is_dac_cmd;
   wire logic [31:0] match_addr;
   wire logic dac_hi_ok;
   wire logic [6:0] raw_hit;
   wire logic [5:0] bar_hit;
   wire logic rom_hit;
   wire logic pair01;
   wire logic pair12;
   wire logic decode_ok;
   wire logic claim;
   wire logic wide_now;
   wire logic xfr_now;

   assign in_idle = state_reg == tsv_pkg::TSV_IDLE;
   assign in_dac = state_reg == tsv_pkg::TSV_DAC;
   assign in_active = state_reg == tsv_pkg::TSV_ACTIVE;
   assign addr_phase = in_idle & ~pci.framen & frame_prev_reg;
   assign bus_idle = pci.framen & pci.irdyn;
   assign cmd_ok = (pci.cben[3:1] != `TSV_CMD_CFG) & (pci.cben[3:1] != `TSV_CMD_SPC);
   assign is_dac_cmd = pci.cben == `TSV_CMD_DAC;
   assign match_addr = in_dac ? addr_lo_reg : pci.ad;
   assign dac_hi_ok = ~in_dac | (pci.ad == dac_hi_reg);
   assign pair01 = ctrl_reg[`TSV_CTRL_PAIR01];
   assign pair12 = ctrl_reg[`TSV_CTRL_PAIR12] & ~pair01;

   // One comparator per window, bit i of raw_hit for window register i.
   generate
      for (genvar i = 0; i < 7; i++) begin : g_win
         tsv_window_match #(.AW(32)) u_match ( // see R2
            .addr(match_addr),
            .base(base_reg[i]),
            .mask(mask_reg[i]),
            .enable(ctrl_reg[i]),
            .hit(raw_hit[i])
         );
      end
   endgenerate

   assign bar_hit[0] = raw_hit[0]; // see R1
   assign bar_hit[1] = pair01 ? raw_hit[0] : raw_hit[1]; // see R3
   assign bar_hit[2] = pair12 ? raw_hit[1] : raw_hit[2]; // see R4
   assign bar_hit[5:3] = raw_hit[5:3];
   assign rom_hit = raw_hit[`TSV_ROM_IDX] & ~in_dac; // see R5
   assign decode_ok = (addr_phase & ~is_dac_cmd) | in_dac;
   assign claim = decode_ok & cmd_ok & dac_hi_ok & ((|bar_hit) | rom_hit);
   assign wide_now = in_dac ? req64_lat_reg : ~pci.req64n;
   assign xfr_now = ~pci.irdyn & ~pci.trdyn;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         tsv_pkg::TSV_IDLE: begin
            if (addr_phase) begin
               if (is_dac_cmd) begin
                  state_next = tsv_pkg::TSV_DAC;
               end else if (claim) begin
                  state_next = tsv_pkg::TSV_ACTIVE;
               end else begin
                  state_next = tsv_pkg::TSV_MISS;
               end
            end
         end
         tsv_pkg::TSV_DAC: begin
            state_next = claim ? tsv_pkg::TSV_ACTIVE : tsv_pkg::TSV_MISS;
         end
         tsv_pkg::TSV_MISS: begin
            state_next = bus_idle ? tsv_pkg::TSV_IDLE : tsv_pkg::TSV_MISS;
         end
         tsv_pkg::TSV_ACTIVE: begin
            state_next = bus_idle ? tsv_pkg::TSV_IDLE : tsv_pkg::TSV_ACTIVE;
         end
         default: begin
            state_next = tsv_pkg::TSV_IDLE;
         end
      endcase
   end

   always_comb begin
      tsv_next = '0; // see R14
      if (state_next == tsv_pkg::TSV_ACTIVE) begin
         if (in_active) begin
            tsv_next = tsv_reg;
            tsv_next.xfr = xfr_now; // see R10
            if (first_reg & ~pci.irdyn) begin
               tsv_next.burst = ~pci.framen; // see R9
            end
         end else begin
            tsv_next.bar_hit = bar_hit; // see R1
            tsv_next.rom_hit = rom_hit; // see R5
            tsv_next.wide = (WIDE64 == 1) & wide_now; // see R6 see R7
            tsv_next.access = 1'b1; // see R8
            tsv_next.dac = in_dac; // see R11
         end
      end
   end

   assign first_next = (state_next == tsv_pkg::TSV_ACTIVE)
                       & (~in_active | (first_reg & pci.irdyn));

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= tsv_pkg::TSV_IDLE;
         tsv_reg <= '0; // see R14
         frame_prev_reg <= 1'b1;
         addr_lo_reg <= `TSV_REG_RST;
         req64_lat_reg <= 1'b0;
         first_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tsv_reg <= tsv_next;
         frame_prev_reg <= pci.framen;
         addr_lo_reg <= addr_phase ? pci.ad : addr_lo_reg;
         req64_lat_reg <= addr_phase ? ~pci.req64n : req64_lat_reg;
         first_reg <= first_next;
      end
   end

   assign target_status_vector = tsv_reg; // see R13

   // AXI4-Lite write channel.
   logic aw_full_reg;
   logic w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;

   wire logic aw_take;
   wire logic w_take;
   wire logic do_wr;
   wire logic aw_full_next;
   wire logic w_full_next;
   wire logic bvalid_next;
   wire logic [5:0] wr_w;
   wire logic [5:0] wr_boff;
   wire logic [5:0] wr_moff;
   wire logic wr_ctrl;
   wire logic wr_dachi;
   wire logic wr_status;
   wire logic wr_base;
   wire logic wr_mask;
   wire logic wr_ok;

   assign aw_take = s_axi_awvalid & awready_reg;
   assign w_take = s_axi_wvalid & wready_reg;
   assign do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign aw_full_next = (aw_full_reg & ~do_wr) | aw_take;
   assign w_full_next = (w_full_reg & ~do_wr) | w_take;
   assign bvalid_next = do_wr | (bvalid_reg & ~s_axi_bready);
   assign wr_w = aw_addr_reg[7:2];
   assign wr_boff = wr_w - `TSV_BASE_W;
   assign wr_moff = wr_w - `TSV_MASK_W;
   assign wr_ctrl = wr_w == `TSV_CTRL_W;
   assign wr_dachi = wr_w == `TSV_DACHI_W;
   assign wr_status = wr_w == `TSV_STATUS_W;
   assign wr_base = (wr_w >= `TSV_BASE_W) & (wr_boff <= `TSV_WIN_LAST);
   assign wr_mask = (wr_w >= `TSV_MASK_W) & (wr_moff <= `TSV_WIN_LAST);
   assign wr_ok = wr_ctrl | wr_dachi | wr_status | wr_base | wr_mask;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         wdata_reg <= `TSV_REG_RST;
         wstrb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `TSV_RESP_OKAY;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         aw_addr_reg <= aw_take ? s_axi_awaddr : aw_addr_reg;
         wdata_reg <= w_take ? s_axi_wdata : wdata_reg;
         wstrb_reg <= w_take ? s_axi_wstrb : wstrb_reg;
         awready_reg <= ~aw_full_next & ~bvalid_next;
         wready_reg <= ~w_full_next & ~bvalid_next;
         bvalid_reg <= bvalid_next;
         if (do_wr) begin
            bresp_reg <= wr_ok ? `TSV_RESP_OKAY : `TSV_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctrl_reg <= `TSV_REG_RST;
         dac_hi_reg <= `TSV_REG_RST;
         for (int i = 0; i < 7; i++) begin
            base_reg[i] <= `TSV_REG_RST;
            mask_reg[i] <= `TSV_REG_RST;
         end
      end else if (do_wr) begin
         if (wr_ctrl) begin
            ctrl_reg <= merge_strb(ctrl_reg, wdata_reg, wstrb_reg) & `TSV_CTRL_MASK;
         end
         if (wr_dachi) begin
            dac_hi_reg <= merge_strb(dac_hi_reg, wdata_reg, wstrb_reg);
         end
         if (wr_base) begin
            base_reg[wr_boff[2:0]] <= merge_strb(base_reg[wr_boff[2:0]], wdata_reg, wstrb_reg);
         end
         if (wr_mask) begin
            mask_reg[wr_moff[2:0]] <= merge_strb(mask_reg[wr_moff[2:0]], wdata_reg, wstrb_reg);
         end
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // AXI4-Lite read channel.
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   wire logic ar_take;
   wire logic rvalid_next;
   wire logic [5:0] rd_w;
   wire logic [5:0] rd_boff;
   wire logic [5:0] rd_moff;
   wire logic rd_base;
   wire logic rd_mask;
   wire logic rd_ok;
   wire logic [31:0] rd_word;

   assign ar_take = s_axi_arvalid & arready_reg;
   assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
   assign rd_w = s_axi_araddr[7:2];
   assign rd_boff = rd_w - `TSV_BASE_W;
   assign rd_moff = rd_w - `TSV_MASK_W;
   assign rd_base = (rd_w >= `TSV_BASE_W) & (rd_boff <= `TSV_WIN_LAST);
   assign rd_mask = (rd_w >= `TSV_MASK_W) & (rd_moff <= `TSV_WIN_LAST);
   assign rd_ok = (rd_w == `TSV_CTRL_W) | (rd_w == `TSV_STATUS_W)
                  | (rd_w == `TSV_DACHI_W) | rd_base | rd_mask;
   assign rd_word = (rd_w == `TSV_CTRL_W) ? ctrl_reg
                  : (rd_w == `TSV_STATUS_W) ? {20'h00000, tsv_reg}
                  : (rd_w == `TSV_DACHI_W) ? dac_hi_reg
                  : rd_base ? base_reg[rd_boff[2:0]]
                  : rd_mask ? mask_reg[rd_moff[2:0]]
                  : `TSV_REG_RST;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= `TSV_REG_RST;
         rresp_reg <= `TSV_RESP_OKAY;
      end else begin
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= ar_take ? rd_word : rdata_reg;
         if (ar_take) begin
            rresp_reg <= rd_ok ? `TSV_RESP_OKAY : `TSV_RESP_SLVERR;
         end
      end
   end

   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Checks on the status vector and the write response.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   a_hit_needs_access: assert property ( // see R1
      (|target_status_vector.bar_hit) |-> target_status_vector.access)
      else $error("Window hit shown without target access.");
   a_pair_low_win: assert property ( // see R3
      (target_status_vector.bar_hit[0] && $past(pair01)) |-> target_status_vector.bar_hit[1])
      else $error("Paired low window hit lacks its upper bit.");
   a_pair_mid_win: assert property ( // see R4
      (target_status_vector.bar_hit[1] && $past(pair12)) |-> target_status_vector.bar_hit[2])
      else $error("Paired middle window hit lacks its upper bit.");
   a_rom_in_access: assert property ( // see R5
      target_status_vector.rom_hit |-> target_status_vector.access && !target_status_vector.dac)
      else $error("Expansion ROM hit outside a single address access.");
   a_wide_tracks_req: assert property ( // see R6
      $rose(target_status_vector.access) |-> target_status_vector.wide == (WIDE64 == 1 &&
      ($past(in_dac) ? $past(req64_lat_reg) : !$past(pci.req64n))))
      else $error("Width flag does not follow the 64-bit request.");
   a_narrow_no_wide: assert property ( // see R7
      (WIDE64 == 0) |-> !target_status_vector.wide)
      else $error("Width flag set in a narrow variant.");
   a_access_holds: assert property ( // see R8
      (target_status_vector.access && !bus_idle) |=> target_status_vector.access)
      else $error("Target access dropped while the bus was busy.");
   a_burst_sample: assert property ( // see R9
      (in_active && first_reg && !pci.irdyn && !pci.framen && state_next == tsv_pkg::TSV_ACTIVE)
      |=> target_status_vector.burst)
      else $error("Burst not flagged after a first-phase burst.");
   a_xfr_follows: assert property ( // see R10
      target_status_vector.xfr |-> $past(in_active) && !$past(pci.irdyn) && !$past(pci.trdyn))
      else $error("Transfer flag without a PCI transfer one cycle before.");
   a_dac_entry: assert property ( // see R11
      $rose(target_status_vector.access) |-> target_status_vector.dac == $past(in_dac))
      else $error("Dual address flag does not match the address phase.");
   a_idle_zero: assert property ( // see R14
      !target_status_vector.access |-> target_status_vector == '0)
      else $error("Status bits set with no claimed access.");
   a_bresp_hold: assert property (
      s_axi_bvalid |=> $past(s_axi_bready) || (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("Write response dropped before it was taken.");

endmodule

`default_nettype wire

// file: bench/tsv_local_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Local-side watcher: it samples the status bus each clock and drives nothing back.
module tsv_local_monitor (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire tsv_pkg::tsv_status_t target_status_vector,
   output logic [15:0] done_count
);
   logic access_reg;
   logic [15:0] done_next;
   assign done_next = done_count + 16'h0001;
   // Counts finished target accesses seen on the sampled bus.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         access_reg <= 1'b0;
         done_count <= 16'h0000;
      end else begin
         access_reg <= target_status_vector.access;
         if (access_reg && !target_status_vector.access) begin
            done_count <= done_next;
         end
      end
   end
endmodule

`default_nettype wire

// file: bench/target_txn_status_vector_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsv_defs.svh"

module target_txn_status_vector_test;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   tsv_pkg::tsv_pci_t pci = 40'hff00000000;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd, a, ctrl, dac_hi;
   logic [31:0] base [0:6];
   logic [31:0] mask [0:6];
   logic [31:0] seed = 32'h45e28fd9;
   tsv_pkg::tsv_status_t vec;
   logic [15:0] done_count;
   int fails = 0, checks = 0, cycles = 0, claims = 0;

   always #2 clk_sys = ~clk_sys;

   tsv_status_top #(.WIDE64(1)) u_tsv_status_top (
      .clk_sys(clk_sys), .rstn(rstn), .pci(pci),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .target_status_vector(vec));

   tsv_local_monitor u_tsv_local_monitor (
      .clk_sys(clk_sys), .rstn(rstn), .target_status_vector(vec), .done_count(done_count));

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic logic [6:0] exp_hits(input logic [31:0] ad, input logic dac);
      logic [6:0] h;
      for (int i = 0; i < 7; i++) begin
         h[i] = ctrl[i] && ((ad & mask[i]) == (base[i] & mask[i]));
      end
      if (dac) begin
         h[6] = 1'b0;
      end
      if (ctrl[8]) begin
         h[1] = h[0];
      end else if (ctrl[9]) begin
         h[2] = h[1];
      end
      exp_hits = h;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         $display("[FAIL] %0t timeout", $time);
         wrap_up();
      end
   end

   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_sys);
      awaddr <= ad;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] ad);
      @(posedge clk_sys);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // Address phase (two for a dual address cycle), data phases, then two idle cycles.
   task automatic pci_txn(input logic [31:0] ad, input logic [3:0] cmd, input logic dac,
                          input logic burst, input logic w64);
      tsv_pkg::tsv_status_t e;
      logic [6:0] h;
      logic claim;
      int n;
      h = exp_hits(ad, dac);
      claim = (h != 7'h00) && (cmd[3:1] != 3'h5) && (cmd[3:1] != 3'h0);
      n = burst ? 3 : 1;
      @(posedge clk_sys);
      pci.framen <= 1'b0;
      pci.req64n <= !w64;
      pci.ad <= ad;
      pci.cben <= dac ? `TSV_CMD_DAC : cmd;
      if (dac) begin
         @(posedge clk_sys);
         pci.ad <= dac_hi;
         pci.cben <= cmd;
      end
      for (int p = 0; p <= n; p++) begin
         @(posedge clk_sys);
         seed = lfsr(seed);
         pci.ad <= seed;
         pci.cben <= 4'h0;
         pci.framen <= (p >= n - 1);
         pci.irdyn <= (p == n);
         pci.trdyn <= (p == n) || (burst && p == 0);
         pci.req64n <= (p == n) || !w64;
         if (p >= 1) begin
            @(negedge clk_sys);
            e = claim ? {dac, !(burst && p == 1), burst, 1'b1, w64, h} : 12'h000;
            check(vec, e, "status during access");
         end
      end
      @(posedge clk_sys);
      seed = lfsr(seed);
      pci.ad <= seed;
      @(negedge clk_sys);
      check(vec, 32'h0, "status after access");
      if (claim) begin
         claims++;
      end
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check(vec, 32'h0, "status after reset");
      axi_rd(8'h0c);
      check(resp, `TSV_RESP_SLVERR, "unmapped read");
      axi_wr(8'h04, 32'hffffffff, 4'hf);
      check(resp, `TSV_RESP_OKAY, "status write");
      axi_wr(8'h4c, 32'hffffffff, 4'hf);
      check(resp, `TSV_RESP_SLVERR, "unmapped write");
      axi_rd(8'h04);
      check(rd, 32'h0, "status read idle");
      axi_wr(8'h00, 32'hffffffff, 4'hf);
      axi_rd(8'h00);
      check(rd, 32'h0000037f, "ctrl readback");
      axi_wr(8'h00, 32'h00000000, 4'h2);
      axi_rd(8'h00);
      check(rd, 32'h0000007f, "ctrl strobe merge");
      $display("test registers done");
      ctrl = 32'h0000007f;
      for (int i = 0; i < 7; i++) begin
         seed = lfsr(seed);
         base[i] = {4'(i + 1), 20'h00000, seed[7:4], 4'h0};
         mask[i] = 32'hf00000f0;
         axi_wr(8'h10 + 8'(4 * i), base[i], 4'hf);
         axi_wr(8'h30 + 8'(4 * i), mask[i], 4'hf);
      end
      seed = lfsr(seed);
      dac_hi = seed;
      axi_wr(8'h08, dac_hi, 4'hf);
      for (int k = 0; k < 32; k++) begin
         seed = lfsr(seed);
         a = {4'(k % 8 + 1), seed[27:0]};
         if (seed[0] && k % 8 < 7) begin
            a[7:4] = base[k % 8][7:4];
         end
         pci_txn(a, {3'h3, seed[1]}, 1'b0, seed[2], seed[3]);
      end
      $display("test random accesses done");
      foreach (base[i]) begin
         pci_txn(base[i], 4'h7, 1'b1, i[0], 1'b1);
      end
      pci_txn(base[6], 4'h6, 1'b0, 1'b0, 1'b1);
      pci_txn(base[0], 4'ha, 1'b0, 1'b0, 1'b0);
      pci_txn(base[0], 4'h0, 1'b0, 1'b1, 1'b0);
      $display("test dual address and refused commands done");
      for (int c = 1; c < 4; c++) begin
         ctrl = {22'h000000, 2'(c), 8'h7f};
         axi_wr(8'h00, ctrl, 4'hf);
         for (int i = 0; i < 3; i++) begin
            pci_txn(base[i] | 32'h00000100, 4'h6, 1'b0, 1'b1, 1'b0);
         end
      end
      $display("test window pairing done");
      ctrl = 32'h0000007e;
      axi_wr(8'h00, ctrl, 4'hf);
      pci_txn(base[0], 4'h6, 1'b0, 1'b0, 1'b1);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check(done_count, 32'(claims), "monitor access count");
      $display("test disabled window and monitor count done");
      wrap_up();
   end
endmodule

`default_nettype wire
